// ===== shared/intr_reset_pkg.sv
// What this block does
// - Fault select writable only from Secure state
// - Fault select steers bus error, fault, NMI
// - Fault select resets to zero
// - Shared bits held once, not per state
// - Bits 10:8 hold read-write priority split
// - Priority split banked per security state
// - Reset gate Secure-only, Non-secure reads zero
// - Reset gate limits reset request to Secure
// - Reset gate cleared on warm reset
// - Writing one to bit 2 requests reset
// - Request bit open to both when ungated
// - Gated request: Non-secure reads zero, ignored
// - Debug clear bit write-only, reads zero
// - Writes need key 0x5FA; key reads 0xFA05
// - Split n makes bits 7:n+1 group
// - Pre-emption compares group priority only
//
// Purpose: Constants for the interrupt and reset control register block.
// Assumes: APB slave, 32-bit data, security state taken from pprot[1].
// Notes:   Register offset is a local choice, not a fixed address.

// ==========================================================================
// Package
// ==========================================================================
package intr_reset_pkg;

	// Bus geometry
	localparam int unsigned ADDR_W     = 12;
	localparam int unsigned DATA_W     = 32;
	localparam int unsigned PRIO_W     = 8;
	localparam int unsigned SPLIT_W    = 3;

	// Register offset (byte address)
	localparam logic [ADDR_W-1:0] CTRL_OFFSET = 12'h00C;

	// Field positions
	localparam int unsigned KEY_MSB       = 31;
	localparam int unsigned KEY_LSB       = 16;
	localparam int unsigned HIGH_RSV_MSB  = 15;
	localparam int unsigned HIGH_RSV_LSB  = 14;
	localparam int unsigned BIT_FAULT_SEL = 13;
	localparam int unsigned MID_RSV_MSB   = 12;
	localparam int unsigned MID_RSV_LSB   = 11;
	localparam int unsigned SPLIT_MSB     = 10;
	localparam int unsigned SPLIT_LSB     = 8;
	localparam int unsigned LOW_RSV_MSB   = 7;
	localparam int unsigned LOW_RSV_LSB   = 4;
	localparam int unsigned BIT_GATE      = 3;
	localparam int unsigned BIT_REQ       = 2;
	localparam int unsigned BIT_DBG_CLR   = 1;
	localparam int unsigned BIT_RSV0      = 0;

	// Key values
	localparam logic [15:0] KEY_WRITE = 16'h05FA;
	localparam logic [15:0] KEY_READ  = 16'hFA05;

	// Reset values
	localparam logic               FAULT_SEL_RST = 1'b0;
	localparam logic               GATE_RST      = 1'b0;
	localparam logic               REQ_RST       = 1'b0;
	localparam logic [SPLIT_W-1:0] SPLIT_RST     = 3'h0;

	// Split value with no group bits at all
	localparam logic [SPLIT_W-1:0] SPLIT_NONE = 3'h7;

	// Security state of an access
	typedef enum logic {SEC_SECURE, SEC_NONSECURE} sec_state_t;

	// Mask of group priority bits for a split value
	function automatic logic [PRIO_W-1:0] group_mask(input logic [SPLIT_W-1:0] split);
		logic [PRIO_W-1:0] m;
		m = 8'hFF;
		if (split == SPLIT_NONE) begin
			m = 8'h00;
		end else begin
			m = 8'hFF << (split + 3'h1);
		end
		return m;
	endfunction

endpackage

// ===== rtl/priority_split.sv
// Purpose: Splits two priorities at the binary point and decides pre-emption.
// Assumes: Lower numeric value means higher urgency.
// Notes:   Purely combinational; the result is registered by the caller.

`timescale 1ns/1ps

// ==========================================================================
// Priority split and compare
// ==========================================================================
module priority_split
	import intr_reset_pkg::*;
(
	// Split point
	input  wire logic [SPLIT_W-1:0] i_split,
	// Priorities to compare
	input  wire logic [PRIO_W-1:0]  i_new_prio,
	input  wire logic [PRIO_W-1:0]  i_active_prio,
	// Results
	output logic      [PRIO_W-1:0]  o_new_group,
	output logic                    o_preempt
);

	wire logic [PRIO_W-1:0] mask;       // Group bit mask
	wire logic [PRIO_W-1:0] act_group;  // Active group priority

	// Bits above the split are group, the rest subpriority
	assign mask        = group_mask(i_split);
	assign o_new_group = i_new_prio & mask;
	assign act_group   = i_active_prio & mask;

	// Subpriority is masked away, so ties never pre-empt
	assign o_preempt   = (o_new_group < act_group);

endmodule

// ===== rtl/secure_int_reset_ctrl_low.sv
// Purpose: Interrupt and reset control register, lower half, two security states.
// Assumes: APB slave; pprot[1] high marks a Non-secure access.
// Notes:   Zero wait states; read data captured in the setup cycle.

`timescale 1ns/1ps

// ==========================================================================
// Top module
// ==========================================================================
module secure_int_reset_ctrl_low
	import intr_reset_pkg::*;
(
	// Clock and warm reset
	input  wire logic              i_clk,
	input  wire logic              i_rst_n,
	// APB slave
	input  wire logic              i_psel,
	input  wire logic              i_penable,
	input  wire logic              i_pwrite,
	input  wire logic [ADDR_W-1:0] i_paddr,
	input  wire logic [DATA_W-1:0] i_pwdata,
	input  wire logic [2:0]        i_pprot,
	output logic      [DATA_W-1:0] o_prdata,
	output logic                   o_pready,
	output logic                   o_pslverr,
	// Pre-emption query from the exception logic
	input  wire logic              i_cmp_nonsecure,
	input  wire logic [PRIO_W-1:0] i_new_prio,
	input  wire logic [PRIO_W-1:0] i_active_prio,
	output logic                   o_preempt,
	output logic      [PRIO_W-1:0] o_new_group,
	// Security targeting of faults and NMI
	output logic                   o_bus_fault_nonsecure,
	output logic                   o_nmi_nonsecure,
	output logic                   o_fault_target_nonsecure,
	// Split points for each state
	output logic      [SPLIT_W-1:0] o_split_secure,
	output logic      [SPLIT_W-1:0] o_split_nonsecure,
	// Reset and debug requests
	output logic                   o_sys_reset_req,
	output logic                   o_debug_clear_active
);

	// ======================================================================
	// State
	// ======================================================================
	logic               fault_nmi_nonsecure_select;  // Shared copy
	logic [SPLIT_W-1:0] split_secure;                // Secure bank
	logic [SPLIT_W-1:0] split_nonsecure;             // Non-secure bank
	logic               reset_request_secure_only;   // Shared gate
	logic               system_reset_request;        // Sticky request
	logic               debug_pulse;                 // One-cycle strobe
	logic [DATA_W-1:0]  read_data;                   // Captured read word
	logic               preempt;                     // Registered result
	logic [PRIO_W-1:0]  new_group;                   // Registered group

	// ======================================================================
	// Bus decode
	// ======================================================================
	sec_state_t         acc_state;     // State of the current access
	wire logic          is_secure;     // Access from Secure state
	wire logic          addr_hit;      // Register addressed
	wire logic          setup_phase;   // First cycle of a transfer
	wire logic          access_phase;  // Completing cycle
	wire logic          key_ok;        // Write key matches
	wire logic          write_ok;      // Write accepted
	wire logic          req_allowed;   // State may use the reset request

	assign acc_state    = i_pprot[1] ? SEC_NONSECURE : SEC_SECURE;
	assign is_secure    = (acc_state == SEC_SECURE);
	assign addr_hit     = (i_paddr == CTRL_OFFSET);
	assign setup_phase  = i_psel & ~i_penable;
	assign access_phase = i_psel & i_penable;
	// Without the key the whole write is dropped
	assign key_ok       = (i_pwdata[KEY_MSB:KEY_LSB] == KEY_WRITE);
	assign write_ok     = access_phase & i_pwrite & addr_hit & key_ok;
	// Gate closed locks Non-secure out of the request
	assign req_allowed  = is_secure | ~reset_request_secure_only;

	// Zero wait states; unmapped address answers with an error
	assign o_pready  = 1'b1;
	assign o_pslverr = access_phase & ~addr_hit;

	// ======================================================================
	// Next values
	// ======================================================================
	wire logic               next_fault_sel;   // Fault select
	wire logic [SPLIT_W-1:0] next_split_s;     // Secure split
	wire logic [SPLIT_W-1:0] next_split_ns;    // Non-secure split
	wire logic               next_gate;        // Reset gate
	wire logic               next_req;         // Reset request
	wire logic               next_debug;       // Debug strobe

	// Only Secure writes move the fault select
	assign next_fault_sel = (write_ok & is_secure) ?
		i_pwdata[BIT_FAULT_SEL] : fault_nmi_nonsecure_select;
	// Each state reaches its own bank only
	assign next_split_s   = (write_ok & is_secure) ?
		i_pwdata[SPLIT_MSB:SPLIT_LSB] : split_secure;
	assign next_split_ns  = (write_ok & ~is_secure) ?
		i_pwdata[SPLIT_MSB:SPLIT_LSB] : split_nonsecure;
	// Non-secure writes to the gate are ignored
	assign next_gate      = (write_ok & is_secure) ?
		i_pwdata[BIT_GATE] : reset_request_secure_only;
	// Writing one sets; writing zero never withdraws a pending request
	assign next_req       = system_reset_request |
		(write_ok & req_allowed & i_pwdata[BIT_REQ]);
	// Writers must keep this zero; a one only raises a strobe
	assign next_debug     = write_ok & i_pwdata[BIT_DBG_CLR];

	// ======================================================================
	// Read word
	// ======================================================================
	wire logic [DATA_W-1:0]  read_word;   // Value seen by this access
	wire logic [SPLIT_W-1:0] split_view;  // Bank of the accessing state

	assign split_view = is_secure ? split_secure : split_nonsecure;
	assign read_word[KEY_MSB:KEY_LSB]           = KEY_READ;
	assign read_word[HIGH_RSV_MSB:HIGH_RSV_LSB] = 2'h0;
	assign read_word[BIT_FAULT_SEL]             = fault_nmi_nonsecure_select;
	assign read_word[MID_RSV_MSB:MID_RSV_LSB]   = 2'h0;
	assign read_word[SPLIT_MSB:SPLIT_LSB]       = split_view;
	assign read_word[LOW_RSV_MSB:LOW_RSV_LSB]   = 4'h0;
	// Gate invisible from Non-secure state
	assign read_word[BIT_GATE]    = reset_request_secure_only & is_secure;
	assign read_word[BIT_REQ]     = system_reset_request & req_allowed;
	assign read_word[BIT_DBG_CLR] = 1'b0;
	assign read_word[BIT_RSV0]    = 1'b0;

	// ======================================================================
	// Registers
	// ======================================================================
	// One copy of each shared bit, all cleared by warm reset
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			fault_nmi_nonsecure_select <= FAULT_SEL_RST;
			reset_request_secure_only  <= GATE_RST;
			system_reset_request       <= REQ_RST;
			debug_pulse                <= 1'b0;
		end else begin
			fault_nmi_nonsecure_select <= next_fault_sel;
			reset_request_secure_only  <= next_gate;
			system_reset_request       <= next_req;
			debug_pulse                <= next_debug;
		end
	end

	// Banked split points
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			split_secure    <= SPLIT_RST;
			split_nonsecure <= SPLIT_RST;
		end else begin
			split_secure    <= next_split_s;
			split_nonsecure <= next_split_ns;
		end
	end

	// Read data captured in setup; no write can land before access ends
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			read_data <= 32'h0000_0000;
		end else if (setup_phase & ~i_pwrite) begin
			read_data <= addr_hit ? read_word : 32'h0000_0000;
		end
	end

	// ======================================================================
	// Pre-emption
	// ======================================================================
	wire logic [SPLIT_W-1:0] cmp_split;   // Bank for the query
	wire logic               cmp_result;  // Raw compare
	wire logic [PRIO_W-1:0]  cmp_group;   // Raw group

	assign cmp_split = i_cmp_nonsecure ? split_nonsecure : split_secure;

	priority_split u_split (
		.i_split       (cmp_split),
		.i_new_prio    (i_new_prio),
		.i_active_prio (i_active_prio),
		.o_new_group   (cmp_group),
		.o_preempt     (cmp_result)
	);

	// Result registered so the outputs come from flops
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			preempt   <= 1'b0;
			new_group <= 8'h00;
		end else begin
			preempt   <= cmp_result;
			new_group <= cmp_group;
		end
	end

	// ======================================================================
	// Outputs
	// ======================================================================
	// One bit steers all three targets together
	assign o_bus_fault_nonsecure    = fault_nmi_nonsecure_select;
	assign o_nmi_nonsecure          = fault_nmi_nonsecure_select;
	assign o_fault_target_nonsecure = fault_nmi_nonsecure_select;
	assign o_split_secure           = split_secure;
	assign o_split_nonsecure        = split_nonsecure;
	assign o_sys_reset_req          = system_reset_request;
	assign o_debug_clear_active     = debug_pulse;
	assign o_prdata                 = read_data;
	assign o_preempt                = preempt;
	assign o_new_group              = new_group;

	// ======================================================================
	// Assertions
	// ======================================================================
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_rst_n);

	// Keyed write to the register
	sequence s_key_write;
		i_psel && i_penable && i_pwrite && addr_hit && key_ok;
	endsequence

	// Read setup to the register
	sequence s_read_setup;
		i_psel && !i_penable && !i_pwrite && addr_hit;
	endsequence

	AST_NS_FAULT_LOCKED: assert property (
		(s_key_write and !is_secure) |=> $stable(fault_nmi_nonsecure_select))
		else $error("Non-secure write changed fault select");

	AST_FAULT_TARGETS: assert property (
		o_nmi_nonsecure == o_bus_fault_nonsecure &&
		o_fault_target_nonsecure == fault_nmi_nonsecure_select)
		else $error("Fault targets disagree with select");

	AST_RESET_CLEARS: assert property (disable iff (1'b0)
		$rose(i_rst_n) |-> !fault_nmi_nonsecure_select && !reset_request_secure_only)
		else $error("Shared bits not cleared by reset");

	AST_BANK_SPLIT: assert property (
		(s_key_write and is_secure) |=>
		$stable(split_nonsecure) && split_secure == $past(i_pwdata[SPLIT_MSB:SPLIT_LSB]))
		else $error("Secure write reached wrong split bank");

	AST_GATE_HIDDEN: assert property (
		(s_read_setup and !is_secure) |=> !o_prdata[BIT_GATE] &&
		o_prdata[KEY_MSB:KEY_LSB] == KEY_READ)
		else $error("Non-secure read saw gate or bad key");

	AST_GATED_REQUEST: assert property (
		(s_key_write and !is_secure and reset_request_secure_only and
		!system_reset_request) |=> !o_sys_reset_req)
		else $error("Gated Non-secure write raised reset request");

	AST_REQUEST_ISSUED: assert property (
		(s_key_write and req_allowed and i_pwdata[BIT_REQ]) |=> o_sys_reset_req [*2])
		else $error("Reset request not raised and held");

	AST_BAD_KEY: assert property (
		(i_psel && i_penable && i_pwrite && !key_ok) |=>
		$stable(split_secure) && $stable(split_nonsecure) && $stable(o_sys_reset_req))
		else $error("Write without key took effect");

	AST_DEBUG_READS_ZERO: assert property (
		s_read_setup |=> !o_prdata[BIT_DBG_CLR] && o_prdata[LOW_RSV_MSB:LOW_RSV_LSB] == 4'h0)
		else $error("Write-only or reserved bit read nonzero");

	AST_PREEMPT_GROUP: assert property (
		(i_new_prio == i_active_prio) |=> !o_preempt)
		else $error("Equal priorities pre-empted");

	// Secure keyed write lands in the gate and the fault select
	AST_SECURE_GATE_WRITE: assert property (
		(s_key_write and is_secure) |=>
		reset_request_secure_only == $past(i_pwdata[BIT_GATE]) &&
		fault_nmi_nonsecure_select == $past(i_pwdata[BIT_FAULT_SEL]))
		else $error("Secure write missed gate or fault select");

	// Non-secure writes never move the shared gate
	AST_NS_GATE_LOCKED: assert property (
		(s_key_write and !is_secure) |=> $stable(reset_request_secure_only))
		else $error("Non-secure write changed reset gate");

	// Non-secure write reaches its own split bank only
	AST_BANK_SPLIT_NS: assert property (
		(s_key_write and !is_secure) |=>
		$stable(split_secure) && split_nonsecure == $past(i_pwdata[SPLIT_MSB:SPLIT_LSB]))
		else $error("Non-secure write reached wrong split bank");

	// Reserved bits 12:11 and 0 always read back as zero
	AST_RESERVED_ZERO: assert property (
		s_read_setup |=> o_prdata[MID_RSV_MSB:MID_RSV_LSB] == 2'h0 && !o_prdata[BIT_RSV0])
		else $error("Reserved bit read nonzero");

	// Split seven leaves no group bits, so nothing pre-empts
	AST_SPLIT_NONE: assert property (
		(cmp_split == SPLIT_NONE) |=> !o_preempt && o_new_group == 8'h00)
		else $error("Split seven kept group bits");

	// Only warm reset withdraws a pending request
	AST_REQUEST_STICKY: assert property (
		o_sys_reset_req |=> o_sys_reset_req)
		else $error("Reset request dropped without reset");

endmodule

// ===== tb/secure_int_reset_ctrl_low_tb.sv
// Purpose: Self-checking bench for the interrupt and reset control register.
// Assumes: Zero-wait APB slave at CTRL_OFFSET; pprot[1] marks Non-secure.
// Notes:   A small bench model of the register predicts every read back.

`timescale 1ns/1ps

// ==========================================================================
// Testbench top
// ==========================================================================
module secure_int_reset_ctrl_low_tb;
	import intr_reset_pkg::*;

	localparam int MAX_CYCLES = 4000; // Whole run needs well under this

	// Design inputs
	logic              i_clk, i_rst_n, i_psel, i_penable, i_pwrite, i_cmp_nonsecure;
	logic [ADDR_W-1:0] i_paddr;
	logic [DATA_W-1:0] i_pwdata;
	logic [2:0]        i_pprot;
	logic [PRIO_W-1:0] i_new_prio, i_active_prio;
	// Design outputs
	logic [DATA_W-1:0]  o_prdata;
	logic               o_pready, o_pslverr, o_preempt, o_sys_reset_req, o_debug_clear_active;
	logic               o_bus_fault_nonsecure, o_nmi_nonsecure, o_fault_target_nonsecure;
	logic [PRIO_W-1:0]  o_new_group;
	logic [SPLIT_W-1:0] o_split_secure, o_split_nonsecure;
	// Bench model and bookkeeping
	logic               fsel, gate, req;
	logic [SPLIT_W-1:0] split_s, split_ns;
	int                 err_count, cmp_count, cycles;

	secure_int_reset_ctrl_low uut (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_psel(i_psel),
		.i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata),
		.i_pprot(i_pprot), .o_prdata(o_prdata), .o_pready(o_pready), .o_pslverr(o_pslverr),
		.i_cmp_nonsecure(i_cmp_nonsecure), .i_new_prio(i_new_prio),
		.i_active_prio(i_active_prio), .o_preempt(o_preempt), .o_new_group(o_new_group),
		.o_bus_fault_nonsecure(o_bus_fault_nonsecure), .o_nmi_nonsecure(o_nmi_nonsecure),
		.o_fault_target_nonsecure(o_fault_target_nonsecure),
		.o_split_secure(o_split_secure), .o_split_nonsecure(o_split_nonsecure),
		.o_sys_reset_req(o_sys_reset_req), .o_debug_clear_active(o_debug_clear_active));

	// ======================================================================
	// Clock and hang guard
	// ======================================================================
	always #2.5 i_clk = ~i_clk;

	// Cuts a hung handshake short
	always @(posedge i_clk) begin
		cycles <= cycles + 1;
		if (cycles == MAX_CYCLES) begin
			err_count++;
			tally_and_finish();
		end
	end

	// ======================================================================
	// Shared tasks
	// ======================================================================
	task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			err_count++;
			$display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
		end
	endtask

	task automatic tally_and_finish();
		$display("compares %0d mismatches %0d", cmp_count, err_count);
		if (err_count == 0 && cmp_count > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask

	// One APB transfer; held until pready is seen at a rising edge
	task automatic apb(input logic wr, input logic [ADDR_W-1:0] a, input logic [31:0] d,
		input logic ns, output logic [31:0] rd, output logic err);
		@(posedge i_clk);
		i_psel    <= 1'b1;
		i_penable <= 1'b0;
		i_pwrite  <= wr;
		i_paddr   <= a;
		i_pwdata  <= d;
		i_pprot   <= {1'b0, ns, 1'b0};
		@(posedge i_clk);
		i_penable <= 1'b1;
		// Ends when pready is seen high; only the bench timeout ends a hung wait
		do begin
			@(posedge i_clk);
		end while (o_pready !== 1'b1);
		rd = o_prdata;
		err = o_pslverr;
		i_psel    <= 1'b0;
		i_penable <= 1'b0;
	endtask

	// Expected word as seen from one security state
	function automatic logic [31:0] exp_word(input logic ns);
		return {16'hFA05, 2'h0, fsel, 2'h0, ns ? split_ns : split_s, 4'h0,
			ns ? 1'b0 : gate, (ns && gate) ? 1'b0 : req, 2'h0};
	endfunction

	// Write to the register and update the model only if the key is good
	task automatic wr_reg(input logic [31:0] d, input logic ns);
		logic [31:0] rd;
		logic        err;
		apb(1'b1, CTRL_OFFSET, d, ns, rd, err);
		check("write error", 32'(err), 32'h0);
		if (d[31:16] == 16'h05FA) begin
			if (d[2] && !(ns && gate)) req = 1'b1;
			if (!ns) fsel = d[13];
			if (!ns) gate = d[3];
			if (ns) split_ns = d[10:8];
			else split_s = d[10:8];
		end
	endtask

	task automatic rd_reg(input logic ns);
		logic [31:0] rd;
		logic        err;
		apb(1'b0, CTRL_OFFSET, 32'h0, ns, rd, err);
		check("read data", rd, exp_word(ns));
		check("read error", 32'(err), 32'h0);
	endtask

	// Side outputs against the model, after the last write has landed
	task automatic check_outs();
		@(negedge i_clk);
		check("bus fault ns", 32'(o_bus_fault_nonsecure), 32'(fsel));
		check("nmi ns", 32'(o_nmi_nonsecure), 32'(fsel));
		check("fault target ns", 32'(o_fault_target_nonsecure), 32'(fsel));
		check("split secure", 32'(o_split_secure), 32'(split_s));
		check("split nonsecure", 32'(o_split_nonsecure), 32'(split_ns));
		check("reset request", 32'(o_sys_reset_req), 32'(req));
		check("debug clear", 32'(o_debug_clear_active), 32'h0);
	endtask

	// Warm reset in mid-run; everything returns to zero
	task automatic warm_reset();
		@(posedge i_clk);
		i_rst_n <= 1'b0;
		@(posedge i_clk);
		i_rst_n <= 1'b1;
		{fsel, gate, req, split_s, split_ns} = '0;
	endtask

	// ======================================================================
	// Scenarios
	// ======================================================================
	task automatic t_reset_values();
		rd_reg(1'b0);
		rd_reg(1'b1);
		check_outs();
	endtask

	// Fault select from both states, banked split, reserved bits 12:11, 7:4 and 0 set to one
	task automatic t_fault_select();
		wr_reg(32'h05FA_3BF1, 1'b0);
		wr_reg(32'h05FA_1DF1, 1'b1);
		rd_reg(1'b0);
		rd_reg(1'b1);
		check_outs();
		wr_reg(32'h05FA_0300, 1'b0);
		rd_reg(1'b0);
		check_outs();
	endtask

	// Wrong keys leave everything unchanged
	task automatic t_bad_key();
		wr_reg(32'h05FB_270C, 1'b0);
		wr_reg(32'hFA05_270C, 1'b1);
		rd_reg(1'b0);
		check_outs();
	endtask

	// Gate hides the request from Non-secure; only reset releases it
	task automatic t_gate();
		wr_reg(32'h05FA_0308, 1'b0);
		rd_reg(1'b1);
		wr_reg(32'h05FA_0D0C, 1'b1);
		check_outs();
		wr_reg(32'h05FA_030C, 1'b0);
		rd_reg(1'b1);
		rd_reg(1'b0);
		wr_reg(32'h05FA_0308, 1'b0);
		check_outs();
		warm_reset();
		rd_reg(1'b0);
		check_outs();
		wr_reg(32'h05FA_0004, 1'b1);
		rd_reg(1'b1);
		check_outs();
		warm_reset();
	endtask

	// Unmapped word answers with an error and changes nothing
	task automatic t_unmapped();
		logic [31:0] rd;
		logic        err;
		apb(1'b0, CTRL_OFFSET + 12'h004, 32'h0, 1'b0, rd, err);
		check("unmapped read error", 32'(err), 32'h1);
		check("unmapped read data", rd, 32'h0);
		apb(1'b1, CTRL_OFFSET + 12'h004, 32'h05FA_2000, 1'b0, rd, err);
		check("unmapped write error", 32'(err), 32'h1);
		rd_reg(1'b0);
	endtask

	// Every split value in both banks against a fixed priority pair
	task automatic t_query();
		logic [PRIO_W-1:0]  m;
		logic [SPLIT_W-1:0] s;
		for (int n = 0; n < 8; n++) begin
			wr_reg({16'h05FA, 5'h0, 3'(n), 8'h00}, 1'b1);
			wr_reg({16'h05FA, 5'h0, 3'(7 - n), 8'h00}, 1'b0);
			for (int b = 0; b < 2; b++) begin
				s = (b == 1) ? 3'(n) : 3'(7 - n);
				m = (s == 3'h7) ? 8'h00 : 8'hFF << (s + 1);
				@(posedge i_clk);
				i_cmp_nonsecure <= b[0];
				i_new_prio      <= 8'h2C;
				i_active_prio   <= 8'h33;
				@(posedge i_clk);
				@(negedge i_clk);
				check("group", 32'(o_new_group), 32'(8'h2C & m));
				check("preempt", 32'(o_preempt), 32'((8'h2C & m) < (8'h33 & m)));
			end
		end
	endtask

	// ======================================================================
	// Main sequence
	// ======================================================================
	initial begin
		{i_clk, i_rst_n, i_psel, i_penable, i_pwrite, i_cmp_nonsecure} = '0;
		{i_paddr, i_pwdata, i_pprot, i_new_prio, i_active_prio} = '0;
		{fsel, gate, req, split_s, split_ns} = '0;
		{err_count, cmp_count, cycles} = '0;
		repeat (12) @(posedge i_clk);
		i_rst_n <= 1'b1;
		t_reset_values();
		t_fault_select();
		t_bad_key();
		t_gate();
		t_unmapped();
		t_query();
		tally_and_finish();
	end

endmodule
